// ---- src/vhp_pkg.sv ----
// Purpose: Shared constants for the video processor host port
// Assumes: Byte-wide host data, 14-bit video memory address
// Notes: Status layout is frame flag, fifth-sprite flag, collision flag, plane number
package vhp_pkg;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam int PLANE_W = 5;
  localparam int SPR_LIMIT = 4;
  localparam int ST_FRAME_BIT = 7;
  localparam int ST_FIFTH_BIT = 6;
  localparam int ST_COLL_BIT = 5;
  localparam logic [1:0] SETUP_READ = 2'h0;
  localparam logic [1:0] SETUP_WRITE = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 14'h0001;
  localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
  localparam logic [2:0] CNT_RST = 3'h0;
  localparam logic [2:0] CNT_ONE = 3'h1;
  localparam logic [2:0] CNT_LIMIT = 3'h4;
  localparam logic [PLANE_W-1:0] PLANE_RST = 5'h00;
endpackage : vhp_pkg

// ---- src/vhp_port.sv ----
// Purpose: Host access port of a video display processor
// Assumes: Strobes come from external decode of I/O 98 H (memory) and 99 H (control)
// Notes: Strobes are asynchronous and synchronised; actions fire on strobe release
// Contract
// [RQ1] A status read is one byte with write strobe high, read strobe low, mode high, all eight bits driven.
// [RQ2] A memory read is low address byte, high byte with top bits 00, then a data read with mode low.
// [RQ3] Each data byte moved to the host advances the address counter by one.
// [RQ4] External decode makes the read and write strobes only for I/O addresses 98 H and 99 H.
// [RQ5] Address 98 H is a memory data transfer with mode low.
// [RQ6] Address 99 H is a control access with mode high.
// [RQ7] No more than four sprites are shown on any scan line.
// [RQ8] With five or more on a line, the four lowest planes are shown and later ones suppressed.
// [RQ9] Sprite conditions including overflow are reported in the status register.
// [RQ10] Frame, fifth-sprite and collision flags stay set until a status read or reset clears them.
// [RQ11] Overflow with frame flag clear sets the fifth-sprite flag and latches that plane number; the code also needs the fifth-sprite flag clear.
// [RQ12] A write setup sends the second address byte with top bits 01.
// [RQ13] A register write sends data then a byte with top bit 1, four zeros and a 3-bit index.
// [RQ14] The 14-bit address counter wraps from its top back to zero.
`timescale 1ns/1ps
module vhp_port (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic mode_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic [13:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic [7:0] mem_rdata_i,
  output logic reg_wr_o,
  output logic [2:0] reg_idx_o,
  output logic [7:0] reg_data_o,
  input wire logic frame_end_i,
  input wire logic line_start_i,
  input wire logic sprite_hit_i,
  input wire logic [4:0] sprite_plane_i,
  input wire logic collision_i,
  output logic sprite_show_o,
  output logic [7:0] status_o
);
  logic [2:0] pins_s;
  logic rd_n_q, wr_n_q;
  logic [7:0] data_s;
  logic [13:0] addr_q;
  logic [7:0] latch_q;
  logic second_q;
  logic [7:0] stat_q;
  logic [2:0] cnt_q;
  logic rd_done, wr_done, stat_rd, data_rd;
  logic overflow;

  vhp_sync #(.W(3), .RST(3'h7)) u_sync_ctl (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .d_i({read_strobe_n_i, write_strobe_n_i, mode_i}),
    .q_o(pins_s)
  );
  vhp_sync #(.W(8), .RST(8'h00)) u_sync_dat (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .d_i(data_i),
    .q_o(data_s)
  );

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
    end else begin
      rd_n_q <= pins_s[2];
      wr_n_q <= pins_s[1];
    end
  end

  // Rising edge of a strobe completes the byte; data is sampled there
  assign rd_done = pins_s[2] && !rd_n_q;
  assign wr_done = pins_s[1] && !wr_n_q;
  assign stat_rd = rd_done && pins_s[0]; // [RQ1] [RQ6]
  assign data_rd = rd_done && !pins_s[0]; // [RQ5]

  // Read data driven while read strobe is low; memory byte prefetched
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_o <= vhp_pkg::BYTE_RST;
    end else if (pins_s[0]) begin
      data_o <= stat_q; // [RQ1]
    end else begin
      data_o <= mem_rdata_i; // [RQ2]
    end
  end
  assign data_oe_o = !pins_s[2];

  // Two-byte control sequence: address setup or register write
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      latch_q <= vhp_pkg::BYTE_RST;
      second_q <= 1'b0;
      addr_q <= vhp_pkg::ADDR_RST;
      reg_wr_o <= 1'b0;
      reg_idx_o <= 3'h0;
      reg_data_o <= vhp_pkg::BYTE_RST;
      mem_wr_o <= 1'b0;
      mem_wdata_o <= vhp_pkg::BYTE_RST;
    end else begin
      reg_wr_o <= 1'b0;
      mem_wr_o <= 1'b0;
      if (stat_rd) begin
        second_q <= 1'b0; // Status read resynchronises the byte pairing
      end else if (wr_done && pins_s[0]) begin
        if (!second_q) begin
          latch_q <= data_s;
          second_q <= 1'b1;
        end else begin
          second_q <= 1'b0;
          if (data_s[7]) begin
            reg_wr_o <= 1'b1; // [RQ13]
            reg_idx_o <= data_s[2:0];
            reg_data_o <= latch_q;
          end else begin
            addr_q <= {data_s[5:0], latch_q}; // [RQ2] [RQ12]
          end
        end
      end else if (wr_done || data_rd) begin
        second_q <= 1'b0;
        if (wr_done) begin
          mem_wr_o <= 1'b1;
          mem_wdata_o <= data_s;
        end
        addr_q <= addr_q + vhp_pkg::ADDR_ONE; // [RQ3] [RQ14]
      end
    end
  end
  assign mem_addr_o = addr_q;
  assign mem_rd_o = !pins_s[2] && !pins_s[0];

  // Per-line sprite counter; plane order is the caller's, lowest first
  assign overflow = sprite_hit_i && (cnt_q == vhp_pkg::CNT_LIMIT);
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= vhp_pkg::CNT_RST;
    end else if (line_start_i) begin
      cnt_q <= vhp_pkg::CNT_RST;
    end else if (sprite_hit_i && cnt_q != vhp_pkg::CNT_LIMIT) begin
      cnt_q <= cnt_q + vhp_pkg::CNT_ONE; // [RQ7]
    end
  end
  assign sprite_show_o = sprite_hit_i && !line_start_i && (cnt_q != vhp_pkg::CNT_LIMIT); // [RQ8]

  // Sticky flags: set wins over the clearing status read
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stat_q <= vhp_pkg::BYTE_RST;
    end else begin
      if (stat_rd) begin
        stat_q[vhp_pkg::ST_FRAME_BIT] <= frame_end_i; // [RQ10]
        stat_q[vhp_pkg::ST_COLL_BIT] <= collision_i;
        stat_q[vhp_pkg::ST_FIFTH_BIT] <= overflow && !line_start_i;
      end else begin
        if (frame_end_i) stat_q[vhp_pkg::ST_FRAME_BIT] <= 1'b1;
        if (collision_i) stat_q[vhp_pkg::ST_COLL_BIT] <= 1'b1; // [RQ9]
      end
      if (overflow && !line_start_i && !stat_q[vhp_pkg::ST_FRAME_BIT] && !stat_q[vhp_pkg::ST_FIFTH_BIT]) begin
        stat_q[vhp_pkg::ST_FIFTH_BIT] <= 1'b1; // [RQ11]
        stat_q[vhp_pkg::PLANE_W-1:0] <= sprite_plane_i;
      end
    end
  end
  assign status_o = stat_q;

  a_line_limit: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RQ7]
    (cnt_q == vhp_pkg::CNT_LIMIT) |-> !sprite_show_o) else $error("fifth sprite shown");
  a_fifth_set: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RQ11]
    (overflow && !line_start_i && !stat_q[7] && !stat_q[6]) |=> (stat_q[6] && stat_q[4:0] == $past(sprite_plane_i)))
    else $error("fifth flag not latched");
  a_flag_sticky: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RQ10]
    (stat_q[5] && !stat_rd) |=> stat_q[5]) else $error("collision flag lost");
  a_frame_clear: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RQ10]
    (stat_rd && !frame_end_i) |=> !stat_q[7]) else $error("frame flag not cleared");
  a_addr_incr: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RQ3]
    data_rd |=> (addr_q == $past(addr_q) + vhp_pkg::ADDR_ONE)) else $error("address not advanced");
  a_addr_wrap: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RQ14]
    (data_rd && addr_q == 14'h3fff) |=> addr_q == 14'h0000) else $error("address did not wrap");
  a_setup_load: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RQ2]
    (wr_done && pins_s[0] && second_q && !data_s[7]) |=> addr_q == {$past(data_s[5:0]), $past(latch_q)})
    else $error("address setup wrong");
  a_status_drive: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RQ1]
    (!pins_s[2] && pins_s[0] && pins_s[1]) |=> (data_oe_o || $rose(pins_s[2])) && data_o == $past(stat_q))
    else $error("status not driven");
  a_reg_write: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RQ13]
    reg_wr_o |-> ##1 !reg_wr_o) else $error("register write not a pulse");
  a_reg_fields: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RQ13]
    reg_wr_o |-> (reg_idx_o == $past(data_s[2:0]) && reg_data_o == $past(latch_q)))
    else $error("register write fields wrong");
  a_write_incr: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RQ3]
    (wr_done && !pins_s[0]) |=> (addr_q == $past(addr_q) + vhp_pkg::ADDR_ONE))
    else $error("address not advanced on write");
  a_addr_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RQ3]
    !(wr_done || data_rd) |=> addr_q == $past(addr_q)) else $error("address moved without access");
  a_mem_data: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RQ2]
    (!pins_s[2] && !pins_s[0]) |=> data_o == $past(mem_rdata_i)) else $error("memory byte not driven");
  a_show_first: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RQ8]
    (sprite_hit_i && !line_start_i && cnt_q < vhp_pkg::CNT_LIMIT) |-> sprite_show_o)
    else $error("early sprite dropped");
  a_line_reset: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RQ7]
    line_start_i |=> cnt_q == vhp_pkg::CNT_RST) else $error("sprite count not reset");
  a_coll_set: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RQ9]
    collision_i |=> stat_q[vhp_pkg::ST_COLL_BIT]) else $error("collision not reported");
  a_frame_set: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RQ10]
    frame_end_i |=> stat_q[vhp_pkg::ST_FRAME_BIT]) else $error("frame flag not set");
  a_fifth_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RQ10]
    (stat_q[vhp_pkg::ST_FIFTH_BIT] && !stat_rd) |=>
    (stat_q[vhp_pkg::ST_FIFTH_BIT] && $stable(stat_q[vhp_pkg::PLANE_W-1:0])))
    else $error("fifth flag or plane lost");

  c_status_read: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) stat_rd);
  c_mem_read: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) data_rd ##[1:50] data_rd);
  c_overflow: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) overflow);
  c_reg_write: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) reg_wr_o);
  c_addr_wrap: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) data_rd && addr_q == 14'h3fff);
endmodule : vhp_port

// ---- src/vhp_sync.sv ----
// Purpose: Two-flop synchroniser for a bundle of level inputs
// Assumes: Inputs asynchronous to ref_clk_i
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
module vhp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '1
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= RST;
      q_o <= RST;
    end else begin
      s1_q <= d_i;
      q_o <= s1_q;
    end
  end
endmodule : vhp_sync

// ---- testbench/tb_vhp_port.sv ----
// Purpose: Self-checking bench for the host port
// Assumes: Memory data is a pure function of address
// Notes: Long strobe phases trade run time for margin
`timescale 1ns/1ps
module tb_vhp_port;
  logic clk, rstn, rd_n, wr_n, mode, fe, ls, hit, coll, show, mwr, rwr, oe, mrd;
  logic [7:0] wdat, rdat, mrdat, mwdat, rdata, status, cap_d, cap_w, v, wv;
  logic [13:0] maddr, a;
  logic [4:0] plane, p5;
  logic [2:0] ridx, cap_i;
  int n_mismatch = 0;
  int checks_done = 0;
  int n_oe = 0;
  int n_mrd = 0;
  int b_oe, b_mrd;
  function automatic logic [7:0] mem(input logic [13:0] ad);
    return ad[7:0] ^ {2'h0, ad[13:8]};
  endfunction : mem
  assign mrdat = mem(maddr);
  vhp_host host (.ref_clk_i(clk), .rd_data_i(rdat), .rd_n_o(rd_n), .wr_n_o(wr_n), .mode_o(mode), .data_o(wdat));
  vhp_port dut (.ref_clk_i(clk), .rstn_i(rstn), .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n), .mode_i(mode),
    .data_i(wdat), .data_o(rdat), .data_oe_o(oe), .mem_addr_o(maddr), .mem_rd_o(mrd), .mem_wr_o(mwr),
    .mem_wdata_o(mwdat), .mem_rdata_i(mrdat), .reg_wr_o(rwr), .reg_idx_o(ridx), .reg_data_o(rdata),
    .frame_end_i(fe), .line_start_i(ls), .sprite_hit_i(hit), .sprite_plane_i(plane), .collision_i(coll),
    .sprite_show_o(show), .status_o(status));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rwr === 1'b1) cap_i <= ridx;
    if (rwr === 1'b1) cap_d <= rdata;
    if (mwr === 1'b1) cap_w <= mwdat;
  end
  // Counted on the falling edge, clear of the edge that moves them
  always @(negedge clk) begin
    if (oe === 1'b1) n_oe++;
    if (mrd === 1'b1) n_mrd++;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  task automatic line5(input logic [4:0] p);
    pulse(ls);
    for (int i = 0; i < 5; i++) begin
      @(negedge clk);
      hit = 1'b1;
      plane = p + 5'(i);
      #10 chk(16'(show), 16'(i < 4));
    end
    @(negedge clk);
    hit = 1'b0;
  endtask : line5
  task automatic setup(input logic [13:0] ad, input logic [1:0] kind);
    host.xfer(1'b0, 1'b1, ad[7:0], v);
    host.xfer(1'b0, 1'b1, {kind, ad[13:8]}, v);
  endtask : setup
  task automatic finish_test;
    $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    #500_000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    rstn = 1'b0;
    {fe, ls, hit, coll} = 4'h0;
    plane = 5'h00;
    void'($urandom(54));
    repeat (3) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    host.xfer(1'b1, 1'b1, 8'h00, v);
    chk(16'(v), 16'h0000);
    p5 = 5'($urandom % 8);
    line5(p5);
    pulse(coll);
    chk(16'(status), 16'({3'b011, p5 + 5'h4}));
    host.xfer(1'b1, 1'b1, 8'h00, v);
    chk(16'(v), 16'({3'b011, p5 + 5'h4}));
    host.xfer(1'b1, 1'b1, 8'h00, v);
    chk(16'(v), 16'({3'b000, p5 + 5'h4}));
    pulse(fe);
    line5(5'h03);
    host.xfer(1'b1, 1'b1, 8'h00, v);
    chk(16'(v[7:6]), 16'h0002);
    for (int i = 0; i < 8; i++) begin
      a = 14'($urandom);
      host.xfer(1'b0, 1'b1, a[7:0], v);
      host.xfer(1'b0, 1'b1, {5'h10, 3'(i)}, v);
      chk({5'h0, cap_i, cap_d}, {5'h0, 3'(i), a[7:0]});
    end
    for (int k = 0; k < 2; k++) begin
      a = (k == 0) ? 14'($urandom) : 14'h3ffe;
      setup(a, vhp_pkg::SETUP_READ);
      b_oe = n_oe;
      b_mrd = n_mrd;
      for (int i = 0; i < 3; i++) begin
        host.xfer(1'b1, 1'b0, 8'h00, v);
        chk(16'(v), 16'(mem(a + 14'(i))));
      end
      chk(16'(maddr), 16'(14'(a + 14'h3)));
      chk(16'(n_oe - b_oe), 16'h0012);
      chk(16'(n_mrd - b_mrd), 16'h0012);
    end
    a = 14'($urandom);
    setup(a, vhp_pkg::SETUP_WRITE);
    wv = 8'($urandom);
    host.xfer(1'b0, 1'b0, wv, v);
    chk(16'(cap_w), 16'(wv));
    chk(16'(maddr), 16'(14'(a + 14'h1)));
    finish_test();
  end
endmodule : tb_vhp_port

// ---- testbench/vhp_host.sv ----
// Purpose: Host bus model driving the port strobes
// Assumes: Address decode is folded into mode_o
// Notes: Six-cycle phases clear the synchroniser
`timescale 1ns/1ps
module vhp_host (
  input wire logic ref_clk_i,
  input wire logic [7:0] rd_data_i,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic mode_o,
  output logic [7:0] data_o
);
  initial begin
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    mode_o = 1'b1;
    data_o = 8'h00;
  end
  task automatic xfer(input logic rd, input logic md, input logic [7:0] wd, output logic [7:0] rv);
    @(negedge ref_clk_i);
    mode_o = md;
    data_o = rd ? ~data_o : wd;
    @(negedge ref_clk_i);
    if (rd) rd_n_o = 1'b0;
    else wr_n_o = 1'b0;
    repeat (6) @(negedge ref_clk_i);
    rv = rd_data_i;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    // Released bus must not keep the old byte
    data_o = ~data_o;
  endtask : xfer
endmodule : vhp_host
